// file: design/aits_top.sv
// Acquisition trigger sequencer: timebases, begin/stop/pause triggers, hold-done routing
`timescale 1ns/1ns
`include "aits_map.svh"
module aits_top (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [15:0] ft_i,
    output logic [15:0] ft_o,
    output logic [15:0] ft_oe_b_o,
    input wire logic [7:0] sync_i,
    output logic [7:0] sync_o,
    output logic [7:0] sync_oe_b_o,
    input wire logic ctr_i,
    input wire logic star_i,
    input wire logic cmp_i,
    input wire logic sample_tick_base_i,
    output logic sample_tick_o,
    output logic conversion_tick_o,
    output logic hold_done_o,
    output logic [15:0] buf_addr_o,
    output logic acq_active_o,
    output aits_pkg::aits_state_t state_o
);
    import aits_pkg::*;

    logic [31:0] mode;
    logic [31:0] src_sel;
    logic [31:0] route;
    logic [15:0] cdiv;
    logic [15:0] sdiv;
    logic [15:0] delay;
    logic [15:0] count;
    logic [15:0] pre;
    logic [15:0] chans;
    aits_state_t state;
    logic [15:0] dly_cnt;
    logic [15:0] sdiv_cnt;
    logic [15:0] cdiv_cnt;
    logic [15:0] conv_left;
    logic [15:0] total;
    logic [15:0] fill;
    logic [15:0] buf_ptr;
    logic [15:0] post_left;
    logic sb_raw_rise;
    logic begin_lvl;
    logic begin_rise;
    logic stop_lvl;
    logic stop_rise;
    logic pause_lvl;
    logic pause_rise;
    logic sw_begin;
    logic sw_end;
    logic sb_tick;
    logic cb_tick;
    logic begin_evt;
    logic stop_evt;
    logic paused;
    logic sample_tick;
    logic conv_begin;
    logic hold_pulse;
    logic armed;
    logic last_sample;
    logic [31:0] next_rdata;
    aits_kind_t bkind;
    aits_kind_t skind;
    aits_kind_t pkind;

    // Index 0-15 function terminals, 16-23 sync lines, then counter and star line
    function automatic logic pick_src(input logic [4:0] idx, input logic [15:0] ft,
                                      input logic [7:0] sy, input logic ctr, input logic star);
        logic v;
        v = 1'b0;
        if (idx < 5'h10) begin
            v = ft[idx[3:0]];
        end else if (idx < `AITS_IDX_CTR) begin
            v = sy[idx[2:0]];
        end else if (idx == `AITS_IDX_CTR) begin
            v = ctr;
        end else if (idx == `AITS_IDX_STAR) begin
            v = star;
        end
        return v;
    endfunction : pick_src

    // Down-counter that reloads from the divisor on reaching zero
    function automatic logic [15:0] div_step(input logic [15:0] cnt, input logic [15:0] div);
        return (cnt == 16'h0000) ? div : cnt - 16'h0001;
    endfunction : div_step

    assign bkind = aits_kind_t'(mode[`AITS_MODE_BKIND]);
    assign skind = aits_kind_t'(mode[`AITS_MODE_SKIND]);
    assign pkind = aits_kind_t'(mode[`AITS_MODE_PKIND]);

    // Every external source is synchronised before any edge or level logic
    aits_sync u_sb (.clk_i(clk_i), .rst_b_i(rst_b_i), .raw_i(sample_tick_base_i),
                    .inv_i(1'b0), .level_o(), .rise_o(sb_raw_rise));
    aits_sync u_begin (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .raw_i(bkind == AITS_SRC_ANA ? cmp_i :
               pick_src(src_sel[`AITS_SRC_BEGIN], ft_i, sync_i, ctr_i, star_i)),
        .inv_i(bkind == AITS_SRC_DIG && mode[`AITS_MODE_BEDGE]),
        .level_o(begin_lvl), .rise_o(begin_rise));
    // Counter output is not a stop or pause source, so those picks mask it off
    aits_sync u_stop (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .raw_i(skind == AITS_SRC_ANA ? cmp_i :
               (src_sel[`AITS_SRC_STOP] != `AITS_IDX_CTR) &&
               pick_src(src_sel[`AITS_SRC_STOP], ft_i, sync_i, 1'b0, star_i)),
        .inv_i(skind == AITS_SRC_DIG && mode[`AITS_MODE_SEDGE]),
        .level_o(stop_lvl), .rise_o(stop_rise));
    aits_sync u_pause (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .raw_i(pkind == AITS_SRC_ANA ? cmp_i :
               pick_src(src_sel[`AITS_SRC_PAUSE], ft_i, sync_i, 1'b0, star_i)),
        .inv_i(~mode[`AITS_MODE_PLEVEL]), .level_o(pause_lvl), .rise_o(pause_rise));

    assign sw_begin = wr_i && addr_i == `AITS_OFF_CMD && wdata_i[`AITS_CMD_BEGIN];
    assign sw_end = wr_i && addr_i == `AITS_OFF_CMD && wdata_i[`AITS_CMD_END];
    // Analog begin/stop always use the rising edge of the comparison event
    assign begin_evt = (bkind == AITS_SRC_NONE) ? sw_begin : begin_rise;
    assign stop_evt = (skind != AITS_SRC_NONE) && stop_rise;
    // Pause is a pure level: edges of the source play no part
    assign paused = (pkind != AITS_SRC_NONE) && pause_lvl;
    assign sb_tick = mode[`AITS_MODE_SB_EXT] ? sb_raw_rise : 1'b1;
    // The 20 MHz timebase is the system clock itself, so its tick is every cycle
    assign cb_tick = mode[`AITS_MODE_CB_INT] ? 1'b1 : sb_tick;
    assign sample_tick = (state == AITS_RUN || state == AITS_POST) && !paused &&
                         sb_tick && sdiv_cnt == 16'h0000;
    assign conv_begin = conv_left != 16'h0000 && cb_tick && cdiv_cnt == 16'h0000;
    assign hold_pulse = conv_begin;
    assign armed = fill >= pre;
    assign last_sample = post_left <= 16'h0001;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mode <= `AITS_MODE_RESET;
            src_sel <= 32'h0000_0000;
            route <= 32'h0000_0000;
            cdiv <= `AITS_DIV_RESET;
            sdiv <= `AITS_DIV_RESET;
            delay <= `AITS_DELAY_RESET;
            count <= 16'h0000;
            pre <= 16'h0000;
            chans <= `AITS_CHANS_RESET;
        end else if (wr_i && state == AITS_IDLE) begin
            // Configuration is frozen during an acquisition to keep counts coherent
            if (addr_i == `AITS_OFF_MODE) begin
                mode <= wdata_i;
            end else if (addr_i == `AITS_OFF_SRC) begin
                src_sel <= wdata_i;
            end else if (addr_i == `AITS_OFF_ROUTE) begin
                route <= wdata_i;
            end else if (addr_i == `AITS_OFF_CDIV) begin
                cdiv <= wdata_i[15:0];
            end else if (addr_i == `AITS_OFF_SDIV) begin
                sdiv <= wdata_i[15:0];
            end else if (addr_i == `AITS_OFF_DELAY) begin
                delay <= wdata_i[15:0];
            end else if (addr_i == `AITS_OFF_COUNT) begin
                count <= wdata_i[15:0];
            end else if (addr_i == `AITS_OFF_PRE) begin
                pre <= wdata_i[15:0];
            end else if (addr_i == `AITS_OFF_CHANS) begin
                chans <= wdata_i[15:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state <= AITS_IDLE;
        end else begin
            case (state)
                AITS_IDLE: begin
                    if (begin_evt) begin
                        state <= AITS_DELAY;
                    end
                end
                AITS_DELAY: begin
                    if (sw_end) begin
                        state <= AITS_IDLE;
                    end else if (sb_tick && dly_cnt <= 16'h0001) begin
                        state <= AITS_RUN;
                    end
                end
                AITS_RUN: begin
                    if (sw_end) begin
                        state <= AITS_IDLE;
                    end else if (mode[`AITS_MODE_STOPEN]) begin
                        if (stop_evt && armed) begin
                            state <= (count > pre) ? AITS_POST : AITS_IDLE;
                        end
                    end else if (!mode[`AITS_MODE_CONT] && sample_tick &&
                                 total + 16'h0001 >= count) begin
                        state <= AITS_IDLE;
                    end
                end
                AITS_POST: begin
                    if (sw_end || (sample_tick && last_sample)) begin
                        state <= AITS_IDLE;
                    end
                end
                default: begin
                    state <= AITS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            dly_cnt <= `AITS_DELAY_RESET;
        end else if (state == AITS_IDLE) begin
            dly_cnt <= delay;
        end else if (state == AITS_DELAY && sb_tick && dly_cnt != 16'h0000) begin
            dly_cnt <= dly_cnt - 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sdiv_cnt <= 16'h0000;
        end else if (state != AITS_RUN && state != AITS_POST) begin
            sdiv_cnt <= 16'h0000;
        end else if (sb_tick && !paused) begin
            sdiv_cnt <= div_step(sdiv_cnt, sdiv - 16'h0001);
        end
    end

    // Conversions are gated off until a sample tick opens a burst of chans conversions
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            conv_left <= 16'h0000;
            cdiv_cnt <= 16'h0000;
        end else if (sample_tick) begin
            conv_left <= chans;
            cdiv_cnt <= 16'h0000;
        end else if (cb_tick && conv_left != 16'h0000) begin
            cdiv_cnt <= div_step(cdiv_cnt, cdiv - 16'h0001);
            if (conv_begin) begin
                conv_left <= conv_left - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            total <= 16'h0000;
            fill <= 16'h0000;
            buf_ptr <= 16'h0000;
        end else if (state == AITS_IDLE) begin
            total <= 16'h0000;
            fill <= 16'h0000;
            buf_ptr <= 16'h0000;
        end else if (sample_tick) begin
            total <= total + 16'h0001;
            if (fill < count) begin
                fill <= fill + 16'h0001;
            end
            // A full buffer wraps, so the newest sample overwrites the oldest
            buf_ptr <= (buf_ptr + 16'h0001 >= count) ? 16'h0000 : buf_ptr + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            post_left <= 16'h0000;
        end else if (state == AITS_RUN && stop_evt && armed) begin
            post_left <= count - pre;
        end else if (state == AITS_POST && sample_tick) begin
            post_left <= post_left - 16'h0001;
        end
    end

    // Routed outputs: hold-done wins a shared terminal, then begin, then stop
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ft_o <= 16'h0000;
            ft_oe_b_o <= 16'hFFFF;
            sync_o <= 8'h00;
            sync_oe_b_o <= 8'hFF;
        end else begin
            for (int i = 0; i < 24; i++) begin
                logic drv;
                logic val;
                drv = 1'b0;
                val = 1'b0;
                if (route[`AITS_RT_HOLDEN] && route[`AITS_RT_HOLD] == 5'(i)) begin
                    drv = 1'b1;
                    val = hold_pulse ~^ mode[`AITS_MODE_HOLDPOL];
                end else if (route[`AITS_RT_BEGINEN] && route[`AITS_RT_BEGIN] == 5'(i)) begin
                    drv = 1'b1;
                    val = begin_evt && state == AITS_IDLE;
                end else if (route[`AITS_RT_STOPEN] && route[`AITS_RT_STOP] == 5'(i)) begin
                    drv = 1'b1;
                    val = stop_evt;
                end else if (i >= 16 && route[`AITS_RT_PAUSEEN] &&
                             route[`AITS_RT_PAUSE] == 3'(i - 16)) begin
                    drv = 1'b1;
                    val = paused;
                end
                if (i < 16) begin
                    ft_o[i] <= val;
                    ft_oe_b_o[i] <= ~drv;
                end else begin
                    sync_o[i - 16] <= val;
                    sync_oe_b_o[i - 16] <= ~drv;
                end
            end
        end
    end

    // Conversion tick base is not routed itself; its bursts leave as conversion_tick_o, hold_done_o and any routed hold-done terminal
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sample_tick_o <= 1'b0;
            conversion_tick_o <= 1'b0;
            hold_done_o <= 1'b0;
            buf_addr_o <= 16'h0000;
            acq_active_o <= 1'b0;
            state_o <= AITS_IDLE;
        end else begin
            sample_tick_o <= sample_tick;
            conversion_tick_o <= conv_begin;
            hold_done_o <= hold_pulse ~^ mode[`AITS_MODE_HOLDPOL];
            buf_addr_o <= buf_ptr;
            acq_active_o <= state != AITS_IDLE;
            state_o <= state;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (addr_i == `AITS_OFF_MODE) begin
            next_rdata = mode;
        end else if (addr_i == `AITS_OFF_SRC) begin
            next_rdata = src_sel;
        end else if (addr_i == `AITS_OFF_ROUTE) begin
            next_rdata = route;
        end else if (addr_i == `AITS_OFF_CDIV) begin
            next_rdata = {16'h0000, cdiv};
        end else if (addr_i == `AITS_OFF_SDIV) begin
            next_rdata = {16'h0000, sdiv};
        end else if (addr_i == `AITS_OFF_DELAY) begin
            next_rdata = {16'h0000, delay};
        end else if (addr_i == `AITS_OFF_COUNT) begin
            next_rdata = {16'h0000, count};
        end else if (addr_i == `AITS_OFF_PRE) begin
            next_rdata = {16'h0000, pre};
        end else if (addr_i == `AITS_OFF_CHANS) begin
            next_rdata = {16'h0000, chans};
        end else if (addr_i == `AITS_OFF_STATUS) begin
            next_rdata = {25'h000_0000, begin_lvl, stop_lvl, pause_rise, paused, armed, state};
        end else if (addr_i == `AITS_OFF_SCOUNT) begin
            next_rdata = {fill, total};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    sequence s_stop_taken;
        state == AITS_RUN && mode[`AITS_MODE_STOPEN] && stop_evt && armed && !sw_end;
    endsequence

    sequence s_enter_post;
        ##1 (state == AITS_POST && post_left == $past(count) - $past(pre));
    endsequence

    a_idle_no_tick: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        sample_tick |-> (state == AITS_RUN || state == AITS_POST) && !paused)
        else $error("sample tick outside acquisition or during pause");
    a_pause_holds_tick: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        paused [*3] |-> !sample_tick)
        else $error("sample tick while paused");
    a_hold_out_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        conv_begin |=> hold_done_o == mode[`AITS_MODE_HOLDPOL] && conversion_tick_o)
        else $error("hold-done not emitted after conversion begin");
    a_soft_begin: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state == AITS_IDLE && bkind == AITS_SRC_NONE && sw_begin |=> state == AITS_DELAY)
        else $error("software begin not taken");
    a_early_stop_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state == AITS_RUN && mode[`AITS_MODE_STOPEN] && stop_evt && !armed && !sw_end
        |=> state == AITS_RUN)
        else $error("stop trigger honoured before pretrigger count");
    a_post_count_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_stop_taken ##0 count > pre |-> s_enter_post)
        else $error("posttrigger count not buffer minus pretrigger");
    a_post_finish: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state == AITS_POST && sample_tick && post_left == 16'h0001 |=> state == AITS_IDLE)
        else $error("acquisition did not finish after last posttrigger sample");
    a_cont_sw_end: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state != AITS_IDLE && sw_end |=> state == AITS_IDLE ##1 !acq_active_o)
        else $error("software end not honoured");
    a_begin_delay: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state == AITS_IDLE && begin_evt && delay == 16'h0002 && !mode[`AITS_MODE_SB_EXT]
        |=> state == AITS_DELAY [*2] ##1 state == AITS_RUN)
        else $error("begin delay length wrong");
    a_pause_ft_free: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        !route[`AITS_RT_HOLDEN] && !route[`AITS_RT_BEGINEN] && !route[`AITS_RT_STOPEN]
        ##1 1'b1 |-> &ft_oe_b_o)
        else $error("function terminal driven with only pause routed");
endmodule : aits_top

// file: design/aits_map.svh
// Register offsets, field positions, reset values and timing counts of the trigger sequencer
`ifndef AITS_MAP_SVH
`define AITS_MAP_SVH
`define AITS_OFF_CMD 8'h00
`define AITS_OFF_MODE 8'h04
`define AITS_OFF_SRC 8'h08
`define AITS_OFF_ROUTE 8'h0C
`define AITS_OFF_CDIV 8'h10
`define AITS_OFF_SDIV 8'h14
`define AITS_OFF_DELAY 8'h18
`define AITS_OFF_COUNT 8'h1C
`define AITS_OFF_PRE 8'h20
`define AITS_OFF_CHANS 8'h24
`define AITS_OFF_STATUS 8'h28
`define AITS_OFF_SCOUNT 8'h2C
`define AITS_CMD_BEGIN 0
`define AITS_CMD_END 1
`define AITS_MODE_CB_INT 0
`define AITS_MODE_SB_EXT 1
`define AITS_MODE_CONT 2
`define AITS_MODE_STOPEN 3
`define AITS_MODE_HOLDPOL 4
`define AITS_MODE_BKIND 6:5
`define AITS_MODE_BEDGE 7
`define AITS_MODE_SKIND 9:8
`define AITS_MODE_SEDGE 10
`define AITS_MODE_PKIND 12:11
`define AITS_MODE_PLEVEL 13
`define AITS_MODE_RESET 32'h0000_0010
`define AITS_SRC_BEGIN 4:0
`define AITS_SRC_STOP 12:8
`define AITS_SRC_PAUSE 20:16
`define AITS_RT_HOLD 4:0
`define AITS_RT_HOLDEN 5
`define AITS_RT_BEGIN 12:8
`define AITS_RT_BEGINEN 13
`define AITS_RT_STOP 20:16
`define AITS_RT_STOPEN 21
`define AITS_RT_PAUSE 26:24
`define AITS_RT_PAUSEEN 27
`define AITS_IDX_CTR 5'h18
`define AITS_IDX_STAR 5'h19
`define AITS_DELAY_RESET 16'h0002
`define AITS_DIV_RESET 16'h0001
`define AITS_CHANS_RESET 16'h0001
`endif

// file: design/aits_pkg.sv
// Types shared by the trigger sequencer modules
package aits_pkg;
    typedef enum logic [1:0] {AITS_IDLE, AITS_DELAY, AITS_RUN, AITS_POST} aits_state_t;
    typedef enum logic [1:0] {AITS_SRC_NONE, AITS_SRC_DIG, AITS_SRC_ANA} aits_kind_t;
endpackage : aits_pkg

// file: design/aits_sync.sv
// Two-stage synchroniser with polarity select, level and rising-edge outputs
`timescale 1ns/1ns
module aits_sync (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic raw_i,
    input wire logic inv_i,
    output logic level_o,
    output logic rise_o
);
    logic meta;
    logic stable;
    logic prev;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta <= 1'b0;
            stable <= 1'b0;
        end else begin
            meta <= raw_i;
            stable <= meta;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            prev <= 1'b1;
        end else begin
            prev <= stable ^ inv_i;
        end
    end

    // Prev resets high so an inverted source, which reads active straight out of reset, gives no edge
    assign level_o = stable ^ inv_i;
    assign rise_o = level_o & ~prev;
endmodule : aits_sync

// file: verification/aits_far.sv
// Far-side model: trigger terminals, sync lines, star, counter and comparator
`timescale 1ns/1ns
module aits_far (
    input wire logic clk_i,
    input wire logic [4:0] src_i,
    input wire logic lvl_i,
    input wire logic cmp_lvl_i,
    output logic [15:0] ft_o,
    output logic [7:0] sync_o,
    output logic ctr_o,
    output logic star_o,
    output logic cmp_o
);
    // Undriven lines rest low, as the pull-downs on real pins would leave them
    always_ff @(posedge clk_i) begin
        {star_o, ctr_o, sync_o, ft_o} <= lvl_i ? (26'h000_0001 << src_i) : 26'h000_0000;
        cmp_o <= cmp_lvl_i;
    end
endmodule : aits_far

// file: verification/tb_ai_trigger_sequencer.sv
// Self-checking bench for the acquisition trigger sequencer
`timescale 1ns/1ns
`include "aits_map.svh"
module tb_ai_trigger_sequencer;
    logic clk, rst_b, wr, rd, rd_q, lvl, cmp, cmpo, ctr, star, stk, ctk, hd, act, pol;
    logic [7:0] addr, sy, syo, syoe;
    logic [31:0] wd, rdata, seed;
    logic [31:0] expq[$];
    logic [4:0] src;
    logic [15:0] ft, fto, ftoe, ba;
    aits_pkg::aits_state_t st;
    int fails, check_count, n_st, n_ct, n_hd, n_fo;
    aits_top dut (.clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wd), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .ft_i(ft), .ft_o(fto), .ft_oe_b_o(ftoe), .sync_i(sy),
        .sync_o(syo), .sync_oe_b_o(syoe), .ctr_i(ctr), .star_i(star), .cmp_i(cmpo),
        .sample_tick_base_i(1'b0), .sample_tick_o(stk), .conversion_tick_o(ctk),
        .hold_done_o(hd), .buf_addr_o(ba), .acq_active_o(act), .state_o(st));
    aits_far far (.clk_i(clk), .src_i(src), .lvl_i(lvl), .cmp_lvl_i(cmp), .ft_o(ft),
        .sync_o(sy), .ctr_o(ctr), .star_o(star), .cmp_o(cmpo));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] r;
        r = v ^ (v << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction : xs
    task automatic finish_test;
        if (fails == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Each access starts on a fresh rising edge, so back-to-back calls never
    // reassign a strobe within one time step
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1; addr <= a; expq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd_reg
    // Bounded waits: a hang counts as a mismatch and ends the run
    task automatic wait_act(input logic v);
        for (int i = 0; i < 2000 && act !== v; i++) @(negedge clk);
        chk({31'h0, act}, {31'h0, v});
        if (act !== v) finish_test();
    endtask : wait_act
    task automatic wait_tick;
        for (int i = 0; i < 100 && stk !== 1'b1; i++) @(negedge clk);
        chk({31'h0, stk}, 32'h0000_0001);
        if (stk !== 1'b1) finish_test();
    endtask : wait_tick
    always @(posedge clk) rd_q <= rd;
    // Read data stand only in the cycle after the strobe, so look mid-cycle
    always @(negedge clk) begin
        if (rd_q) chk(rdata, expq.pop_front());
        if (stk === 1'b1) n_st++;
        if (ctk === 1'b1) n_ct++;
        if (hd === pol) n_hd++;
        if (ftoe[3] === 1'b0 && fto[3] === pol) n_fo++;
    end
    initial begin
        {wr, rd, lvl, cmp, rst_b, addr, wd, src, pol} = '0;
        seed = 32'h0001_16F1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd_reg(`AITS_OFF_MODE, `AITS_MODE_RESET);
        rd_reg(`AITS_OFF_DELAY, 32'h0000_0002);
        rd_reg(8'h30, 32'h0000_0000);
        chk({16'h0, ftoe}, 32'h0000_FFFF);
        wr_reg(`AITS_OFF_SDIV, 32'h0000_0008);
        wr_reg(`AITS_OFF_CHANS, 32'h0000_0002);
        wr_reg(`AITS_OFF_CDIV, 32'h0000_0002);
        wr_reg(`AITS_OFF_COUNT, 32'h0000_0003);
        wr_reg(`AITS_OFF_ROUTE, 32'h0000_0023);
        for (int p = 1; p >= 0; p--) begin
            pol = p[0];
            wr_reg(`AITS_OFF_MODE, {27'h0, pol, 4'h1});
            wr_reg(`AITS_OFF_CMD, 32'h0000_0001);
            // Counting starts once the new polarity has settled on the outputs
            n_st = 0; n_ct = 0; n_hd = 0; n_fo = 0;
            // State output is registered, so it trails the internal state by a cycle
            repeat (2) @(negedge clk);
            chk({30'h0, st}, {30'h0, aits_pkg::AITS_DELAY});
            repeat (2) @(negedge clk);
            chk({30'h0, st}, {30'h0, aits_pkg::AITS_RUN});
            wait_act(1'b0);
            repeat (20) @(negedge clk);
            chk(n_st, 32'h0000_0003);
            chk(n_ct, 32'h0000_0006);
            chk(n_hd, 32'h0000_0006);
            chk(n_fo, 32'h0000_0006);
        end
        seed = xs(seed);
        wr_reg(`AITS_OFF_COUNT, 32'h0000_0001);
        src <= 5'(seed % 26);
        wr_reg(`AITS_OFF_MODE, 32'h0000_0031);
        wr_reg(`AITS_OFF_SRC, {27'h0, src});
        lvl <= 1'b1;
        wait_act(1'b1);
        wait_act(1'b0);
        wr_reg(`AITS_OFF_CHANS, 32'h0000_0001);
        lvl <= 1'b0;
        wr_reg(`AITS_OFF_COUNT, 32'h0000_0006);
        wr_reg(`AITS_OFF_PRE, 32'h0000_0003);
        wr_reg(`AITS_OFF_MODE, 32'h0000_021D);
        wr_reg(`AITS_OFF_CMD, 32'h0000_0001);
        cmp <= 1'b1;
        repeat (6) @(posedge clk);
        cmp <= 1'b0;
        repeat (60) @(negedge clk);
        chk({30'h0, st}, {30'h0, aits_pkg::AITS_RUN});
        wait_tick();
        @(posedge clk);
        cmp <= 1'b1;
        n_st = 0;
        wait_act(1'b0);
        chk(n_st, 32'h0000_0003);
        // Continuous run outlives the sample count and ends only on software command
        wr_reg(`AITS_OFF_MODE, 32'h0000_0015);
        wr_reg(`AITS_OFF_CMD, 32'h0000_0001);
        repeat (60) @(negedge clk);
        chk({31'h0, act}, 32'h0000_0001);
        wr_reg(`AITS_OFF_CMD, 32'h0000_0002);
        wait_act(1'b0);
        finish_test();
    end
endmodule : tb_ai_trigger_sequencer
